// file: core/serial_adc_io_sequencer.sv
`timescale 1ns/1ps
// Functional notes
// - Chip select high: ignore link, float output.
// - Chip select low enables link and output.
// - Command: address, length, order, polarity bits.
// - Command bits captured on first eight rises.
// - Command input ignored after eighth clock.
// - Transfer lasts 8, 12 or 16 clocks.
// - Previous result shifts out during command capture.
// - Chip select low: first bit at done rise.
// - Chip select toggled: first bit at fall.
// - Later bits advance on falling clock edges.
// - Sample from fourth fall, hold after last.
// - Last fall drops done, starts conversion, except for the power-down address.
// - Done rises in the same cycle the result is latched.
// - Convert only after transfer, internally timed.
// - Reset: done high, command cleared.
// - Chip select high then low resynchronises.
// - Host clocks exact length; conversion follows.
// - Control inputs ignored during setup interval.
// - Current result goes out next transfer.
// - Length codes map; apply to current cycle.
// - Sixteen-bit mode appends four zero bits.
// - Eight-bit mode drops four low bits.
// - Address picks channel, test level, power-down.
module serial_adc_io_sequencer #(
    parameter int STEP_CYCLES = adc_seq_pkg::STEP_CYCLES,
    parameter int SETUP_CYCLES = adc_seq_pkg::SETUP_CYCLES
) (
    // Clock and reset
    input wire logic mclk,
    input wire logic rst,
    // Host serial link
    input wire logic cs_n,
    input wire logic io_clock,
    input wire logic cmd_in,
    output logic result_out,
    output logic result_oe,
    // Analog front end
    input wire logic comparator_high,
    output logic [3:0] channel_select,
    output logic power_down,
    output logic sample_track,
    output logic [11:0] dac_code,
    // Conversion done
    output logic eoc,
    // Command in force
    output logic length_select_hi,
    output logic length_select_lo,
    output logic lsb_first_select,
    output logic twos_complement_select
);

    localparam int TW = adc_seq_pkg::TIMER_W;

    // Whole state of the block
    typedef struct packed {
        adc_seq_pkg::seq_state_type st;
        logic [2:0] cs_sync;
        logic [2:0] clk_sync;
        logic [1:0] din_sync;
        logic [1:0] cmp_sync;
        logic [7:0] cmd;
        logic [7:0] cmd_shift;
        logic [1:0] len_cur;
        logic [4:0] rises;
        logic [4:0] falls;
        logic [15:0] shift;
        logic oe;
        logic [11:0] result;
        logic [11:0] sar;
        logic [3:0] bit_idx;
        logic [TW-1:0] timer;
        logic eoc;
        logic track;
        logic [3:0] chan;
        logic pdown;
    } core_type;

    core_type cur;
    core_type nx;
    logic cs_low;
    logic cs_fell;
    logic clk_rise;
    logic clk_fall;
    logic [4:0] rise_cnt;
    logic [4:0] fall_cnt;
    logic [7:0] cmd_next;

    // Frame length in clocks for a length code
    function automatic logic [4:0] frame_len(input logic [1:0] code);
        if (code == adc_seq_pkg::LEN_8)
            return adc_seq_pkg::FRAME_8;
        else if (code == adc_seq_pkg::LEN_16)
            return adc_seq_pkg::FRAME_16;
        else
            return adc_seq_pkg::FRAME_12;
    endfunction

    // Result laid out so that the first bit to send sits in bit 15
    function automatic logic [15:0] format_word(
        input logic [11:0] res,
        input logic [7:0] cmd
    );
        logic [15:0] w;
        logic [15:0] r;
        int n;
        w = {res[11] ^ cmd[adc_seq_pkg::TWOS_BIT], res[10:0], 4'h0};
        n = int'(frame_len(cmd[adc_seq_pkg::LEN_MSB:adc_seq_pkg::LEN_LSB]));
        r = w;
        // Short frames only send the top bits, so 8-bit mode loses four
        if (cmd[adc_seq_pkg::LSB_FIRST_SELECT_BIT])
        begin
            for (int i = 0; i < adc_seq_pkg::OUT_W; i++)
            begin
                if (i < n)
                    r[15 - i] = w[16 - n + i];
            end
        end
        return r;
    endfunction

    // Clears the per-frame counters at the start of a transfer
    function automatic core_type begin_frame(input core_type c);
        core_type o;
        o = c;
        o.st = adc_seq_pkg::ST_XFER;
        o.rises = 5'h00;
        o.falls = 5'h00;
        o.cmd_shift = adc_seq_pkg::CMD_RESET;
        o.len_cur = c.cmd[adc_seq_pkg::LEN_MSB:adc_seq_pkg::LEN_LSB];
        return o;
    endfunction

    // Edges and levels seen through the synchronisers
    assign cs_low = ~cur.cs_sync[1];
    assign cs_fell = cur.cs_sync[2] & ~cur.cs_sync[1];
    assign clk_rise = cur.clk_sync[1] & ~cur.clk_sync[2];
    assign clk_fall = ~cur.clk_sync[1] & cur.clk_sync[2];
    assign rise_cnt = cur.rises + 5'h01;
    assign fall_cnt = cur.falls + 5'h01;
    assign cmd_next = {cur.cmd_shift[6:0], cur.din_sync[1]};

    // Next-state logic
    always_comb
    begin
        nx = cur;
        nx.cs_sync = {cur.cs_sync[1:0], cs_n};
        nx.clk_sync = {cur.clk_sync[1:0], io_clock};
        nx.din_sync = {cur.din_sync[0], cmd_in};
        nx.cmp_sync = {cur.cmp_sync[0], comparator_high};
        // Drive only inside a transfer opened by a real select fall; the select
        // synchroniser clears to low at reset, and without this gate the pin would
        // be driven for two cycles after reset while the select is still high
        nx.oe = cs_low && (cur.st != adc_seq_pkg::ST_IDLE || cs_fell);
        case (cur.st)
            adc_seq_pkg::ST_IDLE:
            begin
                // Only a real high-to-low change opens a transfer
                if (cs_fell)
                begin
                    nx.st = adc_seq_pkg::ST_SETUP;
                    nx.timer = '0;
                    nx.shift = format_word(cur.result, cur.cmd);
                end
            end
            adc_seq_pkg::ST_SETUP:
            begin
                // Edges during the settling time are ignored
                if (!cs_low)
                    nx.st = adc_seq_pkg::ST_IDLE;
                else if (cur.timer == TW'(SETUP_CYCLES - 1))
                    nx = begin_frame(nx);
                else
                    nx.timer = cur.timer + TW'(1);
            end
            adc_seq_pkg::ST_XFER:
            begin
                if (!cs_low)
                begin
                    // Abandon the frame; sampling stops with it
                    nx.st = adc_seq_pkg::ST_IDLE;
                    nx.track = 1'b0;
                end
                else
                begin
                    if (clk_rise && cur.rises < adc_seq_pkg::CMD_RISES)
                    begin
                        nx.cmd_shift = cmd_next;
                        nx.rises = rise_cnt;
                        // Length is known after six bits and rules this frame
                        if (rise_cnt == adc_seq_pkg::LEN_RISE)
                            nx.len_cur = cmd_next[1:0];
                    end
                    else if (clk_rise)
                        nx.rises = rise_cnt;
                    if (clk_fall)
                    begin
                        nx.falls = fall_cnt;
                        if (fall_cnt == adc_seq_pkg::SAMPLE_FALL)
                            nx.track = 1'b1;
                        if (fall_cnt == frame_len(cur.len_cur))
                        begin
                            // Frame complete: hold sample, latch command
                            nx.track = 1'b0;
                            nx.cmd = cur.cmd_shift;
                            nx.chan = cur.cmd_shift[7:4];
                            nx.shift = {cur.shift[14:0], 1'b0};
                            if (cur.cmd_shift[7:4] == adc_seq_pkg::ADDR_POWER_DOWN)
                            begin
                                // No conversion in power-down; next frame at once
                                nx.pdown = 1'b1;
                                nx = begin_frame(nx);
                            end
                            else
                            begin
                                nx.pdown = 1'b0;
                                nx.st = adc_seq_pkg::ST_CONV;
                                nx.eoc = 1'b0;
                                nx.timer = '0;
                                nx.bit_idx = adc_seq_pkg::SAR_TOP;
                                nx.sar = 12'h800;
                            end
                        end
                        else
                            nx.shift = {cur.shift[14:0], 1'b0};
                    end
                end
            end
            adc_seq_pkg::ST_CONV:
            begin
                if (cs_fell)
                begin
                    // New transfer aborts the conversion, old result kept
                    nx.eoc = 1'b1;
                    nx.st = adc_seq_pkg::ST_SETUP;
                    nx.timer = '0;
                    nx.shift = format_word(cur.result, cur.cmd);
                end
                else if (cur.timer == TW'(STEP_CYCLES - 1))
                begin
                    // One trial bit per step; step outlasts comparator sync
                    nx.timer = '0;
                    if (!cur.cmp_sync[1])
                        nx.sar[cur.bit_idx] = 1'b0;
                    if (cur.bit_idx == 4'h0)
                    begin
                        nx.result = nx.sar;
                        nx.eoc = 1'b1;
                        nx.shift = format_word(nx.sar, cur.cmd);
                        if (cs_low)
                            nx = begin_frame(nx);
                        else
                            nx.st = adc_seq_pkg::ST_IDLE;
                    end
                    else
                    begin
                        nx.bit_idx = cur.bit_idx - 4'h1;
                        nx.sar[cur.bit_idx - 4'h1] = 1'b1;
                    end
                end
                else
                    nx.timer = cur.timer + TW'(1);
            end
            default:
                nx.st = adc_seq_pkg::ST_IDLE;
        endcase
    end

    // State register; chip select seen low at reset is not a fall
    always_ff @(posedge mclk)
    begin
        if (rst)
        begin
            cur <= '0;
            cur.st <= adc_seq_pkg::ST_IDLE;
            cur.eoc <= 1'b1;
            cur.cmd <= adc_seq_pkg::CMD_RESET;
            cur.cmd_shift <= adc_seq_pkg::CMD_RESET;
        end
        else
            cur <= nx;
    end

    // Outputs straight from state flip-flops
    assign result_out = cur.shift[15];
    assign result_oe = cur.oe;
    assign channel_select = cur.chan;
    assign power_down = cur.pdown;
    assign sample_track = cur.track;
    assign dac_code = cur.sar;
    assign eoc = cur.eoc;
    assign length_select_hi = cur.cmd[adc_seq_pkg::LEN_MSB];
    assign length_select_lo = cur.cmd[adc_seq_pkg::LEN_LSB];
    assign lsb_first_select = cur.cmd[adc_seq_pkg::LSB_FIRST_SELECT_BIT];
    assign twos_complement_select = cur.cmd[adc_seq_pkg::TWOS_BIT];

endmodule

// file: core/adc_seq_pkg.sv
package adc_seq_pkg;
    // Command word layout, first bit shifted in is bit 7
    localparam int CMD_W = 8;
    localparam int ADDR_MSB = 7;
    localparam int ADDR_LSB = 4;
    localparam int LEN_MSB = 3;
    localparam int LEN_LSB = 2;
    localparam int LSB_FIRST_SELECT_BIT = 1;
    localparam int TWOS_BIT = 0;
    localparam logic [7:0] CMD_RESET = 8'h00;
    // Output length codes; every other code means 12 bits
    localparam logic [1:0] LEN_8 = 2'h1;
    localparam logic [1:0] LEN_16 = 2'h3;
    // Address code of the power-down state
    localparam logic [3:0] ADDR_POWER_DOWN = 4'he;
    // Result and frame geometry
    localparam int RES_W = 12;
    localparam int OUT_W = 16;
    localparam logic [4:0] FRAME_8 = 5'h08;
    localparam logic [4:0] FRAME_12 = 5'h0c;
    localparam logic [4:0] FRAME_16 = 5'h10;
    localparam logic [4:0] SAMPLE_FALL = 5'h04;
    localparam logic [4:0] LEN_RISE = 5'h06;
    localparam logic [4:0] CMD_RISES = 5'h08;
    localparam logic [3:0] SAR_TOP = 4'hb;
    // Timing; conversion time is a longest time, setup a least time
    localparam int MCLK_NS = 25;
    localparam int CONV_TIME_NS = 10000;
    localparam int CONV_CYCLES = CONV_TIME_NS / MCLK_NS;
    localparam int STEP_CYCLES = CONV_CYCLES / RES_W;
    localparam int CS_SETUP_NS = 1000;
    localparam int SETUP_CYCLES = (CS_SETUP_NS + MCLK_NS - 1) / MCLK_NS;
    localparam int TIMER_W = 8;
    // Sequencer states, one-hot
    typedef enum logic [3:0] {
        ST_IDLE = 4'h1,
        ST_SETUP = 4'h2,
        ST_XFER = 4'h4,
        ST_CONV = 4'h8
    } seq_state_type;
endpackage

// file: tb/adc_seq_assertions.sv
`timescale 1ns/1ps
module adc_seq_assertions #(
    parameter int STEP_CYCLES = 6
) (
    // Clock and reset
    input wire logic mclk,
    input wire logic rst,
    // Link and converter
    input wire logic cs_n,
    input wire logic result_oe,
    input wire logic eoc,
    input wire logic sample_track,
    input wire logic power_down,
    input wire logic [11:0] dac_code,
    // Command in force
    input wire logic [3:0] channel_select,
    input wire logic length_select_hi,
    input wire logic length_select_lo,
    input wire logic lsb_first_select,
    input wire logic twos_complement_select
);
    localparam int LOW_CYC = 12 * STEP_CYCLES;
    localparam int EOC_MAX = LOW_CYC + 8;
    logic [9:0] low_cnt;
    logic [7:0] cmd_now;
    default clocking dcb @(posedge mclk);
    endclocking
    default disable iff (rst);
    // Length of the current conversion; a stuck done would hide behind a plain range check
    always_ff @(posedge mclk)
    begin
        if (rst || eoc)
            low_cnt <= 10'h000;
        else
            low_cnt <= low_cnt + 10'h001;
    end
    // Whole command as one word
    assign cmd_now = {channel_select, length_select_hi, length_select_lo, lsb_first_select,
        twos_complement_select};
    property p_cs_float;
        cs_n [*6] |-> !result_oe;
    endproperty
    a_cs_float: assert property (p_cs_float) else $error("output driven while deselected");
    property p_cs_drive;
        !cs_n [*6] |-> result_oe;
    endproperty
    a_cs_drive: assert property (p_cs_drive) else $error("output not driven when selected");
    property p_done_time;
        $fell(eoc) |-> ##[1:EOC_MAX] $rose(eoc);
    endproperty
    a_done_time: assert property (p_done_time) else $error("conversion never ends");
    // A select fall just before done is an abort, which legally ends the conversion early
    property p_low_len;
        $rose(eoc) && cs_n == $past(cs_n, 4) |-> low_cnt >= 10'(LOW_CYC) &&
            low_cnt <= 10'(LOW_CYC + 3);
    endproperty
    a_low_len: assert property (p_low_len) else $error("conversion length wrong");
    property p_hold_start;
        $fell(eoc) |-> $fell(sample_track);
    endproperty
    a_hold_start: assert property (p_hold_start) else $error("sample not held at start");
    property p_track_hold;
        !eoc |-> !sample_track;
    endproperty
    a_track_hold: assert property (p_track_hold) else $error("sampling during conversion");
    property p_dac_still;
        eoc && $past(eoc) |-> $stable(dac_code);
    endproperty
    a_dac_still: assert property (p_dac_still) else $error("trial code moved while idle");
    property p_cmd_update;
        !$stable(cmd_now) |-> $fell(eoc) || power_down;
    endproperty
    a_cmd_update: assert property (p_cmd_update) else $error("command changed mid cycle");
    property p_reset_state;
        $fell(rst) |-> eoc && !result_oe && !power_down && cmd_now == 8'h00;
    endproperty
    a_reset_state: assert property (p_reset_state) else $error("bad state after reset");
endmodule

// file: tb/adc_host_model.sv
`timescale 1ns/1ps
module adc_host_model (
    // Clock
    input wire logic mclk,
    // Serial link
    output logic cs_n,
    output logic io_clock,
    output logic cmd_in,
    input wire logic result_out
);
    // Idle deselected so the first frame begins with a falling select
    initial
    begin
        cs_n = 1'h1;
        io_clock = 1'h0;
        cmd_in = 1'h0;
    end
    task automatic idle();
        cs_n <= 1'h1;
    endtask
    // One frame of n clocks; the shift clock stands still outside it
    task automatic frame(input logic [7:0] cmd, input int n, input bit keep,
        output logic [15:0] rx);
        rx = 16'h0000;
        if (!keep)
        begin
            cs_n <= 1'h1;
            repeat (6) @(posedge mclk);
            cs_n <= 1'h0;
        end
        cmd_in <= cmd[7]; // First bit settles long before its rise
        repeat (10) @(posedge mclk); // Setup interval
        for (int i = 0; i < n; i++)
        begin
            io_clock <= 1'h1;
            repeat (4) @(posedge mclk);
            rx[15 - i] = result_out;
            io_clock <= 1'h0;
            // Next bit changes with the fall, half a period before its rise
            cmd_in <= (i < 7) ? cmd[6 - i] : ~cmd_in; // MSB first then junk
            repeat (4) @(posedge mclk);
        end
        cmd_in <= ~cmd_in; // Released line shows no stale value
    endtask
endmodule

// file: tb/tb_top.sv
`timescale 1ns/1ps
module tb_top;
    typedef struct packed {
        logic [7:0] cmd;
        logic [11:0] target;
    } row_type;
    localparam int STEP = 6;
    localparam row_type ROWS [8] = '{'{8'h00, 12'h05a3}, '{8'h18, 12'h0c3f}, '{8'h2c, 12'h0801},
        '{8'h3d, 12'h00f0}, '{8'h45, 12'h07ff}, '{8'h57, 12'h0abc}, '{8'hb2, 12'h0800},
        '{8'ha1, 12'h0123}};
    logic mclk, rst, cs_n, io_clock, cmd_in, result_out, result_oe, comparator_high;
    logic power_down, sample_track, eoc, length_select_hi, length_select_lo;
    logic lsb_first_select, twos_complement_select;
    logic [3:0] channel_select;
    logic [11:0] dac_code, target;
    logic [15:0] rx;
    int error_cnt, tests_run;
    int cyc = 0;
    wire [7:0] cmd_now = {channel_select, length_select_hi, length_select_lo, lsb_first_select,
        twos_complement_select};
    serial_adc_io_sequencer #(.STEP_CYCLES(STEP), .SETUP_CYCLES(2)) u_serial_adc_io_sequencer (
        .mclk, .rst, .cs_n, .io_clock, .cmd_in, .result_out, .result_oe, .comparator_high,
        .channel_select, .power_down, .sample_track, .dac_code, .eoc, .length_select_hi,
        .length_select_lo, .lsb_first_select, .twos_complement_select);
    adc_host_model u_adc_host_model (.mclk, .cs_n, .io_clock, .cmd_in, .result_out);
    // Clock
    initial
    begin
        mclk = 1'h0;
        forever #12.5 mclk = ~mclk;
    end
    // Ideal comparator, registered so it changes only at the edge
    always @(posedge mclk)
        comparator_high <= (target >= dac_code);
    // Hang guard, about nine times the expected run
    always @(posedge mclk)
    begin
        cyc <= cyc + 1;
        if (cyc == 20000)
        begin
            error_cnt++;
            $display("mismatch at %0t: timeout", $time);
            results();
        end
    end
    function automatic int nbits(input logic [7:0] c);
        return (c[3:2] == adc_seq_pkg::LEN_8) ? 8 : (c[3:2] == adc_seq_pkg::LEN_16) ? 16 : 12;
    endfunction
    // Expected stream, first bit at the top; pads and truncation come from the alignment
    function automatic logic [15:0] fmt(input logic [11:0] r, input logic [7:0] c);
        logic [15:0] s;
        logic [15:0] t;
        int n;
        n = nbits(c);
        s = {r ^ {c[0], 11'h000}, 4'h0};
        t = s;
        for (int i = 0; i < n; i++)
            t[15 - i] = c[1] ? s[16 - n + i] : s[15 - i];
        return t;
    endfunction
    task automatic check(input logic [15:0] got, input logic [15:0] exp, input string what);
        tests_run++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask
    // Only bits both lengths clock out are defined when the length changes
    task automatic check_stream(input logic [7:0] pc, input logic [11:0] pt, input logic [7:0] c);
        int n;
        logic [15:0] m;
        n = (nbits(pc) < nbits(c)) ? nbits(pc) : nbits(c);
        m = 16'hffff << (16 - n);
        check(rx & m, fmt(pt, pc) & m, "stream");
    endtask
    task automatic wait_done();
        int k;
        k = 0;
        while (eoc !== 1'h1 && k < 300)
        begin
            @(posedge mclk);
            k++;
        end
        check({15'h0000, eoc}, 16'h0001, "done");
    endtask
    task automatic results();
        $display("tests %0d mismatches %0d", tests_run, error_cnt);
        if (error_cnt == 0 && tests_run > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    // Main sequence; the first result after reset is discarded
    initial
    begin
        rst = 1'h1;
        target = 12'h0000;
        error_cnt = 0;
        tests_run = 0;
        repeat (5) @(posedge mclk);
        rst <= 1'h0;
        repeat (2) @(posedge mclk);
        for (int r = 0; r < 8; r++)
        begin
            target <= ROWS[r].target;
            u_adc_host_model.frame(ROWS[r].cmd, nbits(ROWS[r].cmd), 1'b0, rx);
            if (r > 0)
                check_stream(ROWS[r - 1].cmd, ROWS[r - 1].target, ROWS[r].cmd);
            check({15'h0000, eoc}, 16'h0000, "start");
            wait_done();
            check({8'h00, cmd_now}, {8'h00, ROWS[r].cmd}, "cmd");
            $display("row %0d done", r);
        end
        // Select held low: next frame starts from done without setup
        u_adc_host_model.frame(8'h2c, 16, 1'b1, rx);
        check_stream(8'ha1, 12'h0123, 8'h2c);
        wait_done();
        u_adc_host_model.frame(8'he0, 12, 1'b1, rx);
        check_stream(8'h2c, 12'h0123, 8'he0);
        repeat (4) @(posedge mclk);
        check({14'h0000, power_down, eoc}, 16'h0003, "power down");
        $display("held select test done");
        u_adc_host_model.idle();
        repeat (8) @(posedge mclk);
        check({15'h0000, result_oe}, 16'h0000, "float");
        rst <= 1'h1;
        repeat (5) @(posedge mclk);
        rst <= 1'h0;
        @(posedge mclk);
        check({7'h00, eoc, cmd_now}, 16'h0100, "reset");
        @(posedge mclk);
        check({15'h0000, result_oe}, 16'h0000, "float after reset");
        u_adc_host_model.frame(8'h4c, 16, 1'b0, rx);
        wait_done();
        $display("reset test done");
        // Select dropped again mid-conversion: conversion abandoned, old result resent
        target <= 12'h0456;
        u_adc_host_model.frame(8'h10, 12, 1'b0, rx);
        check_stream(8'h4c, 12'h0123, 8'h10);
        u_adc_host_model.frame(8'h10, 12, 1'b0, rx);
        check_stream(8'h10, 12'h0123, 8'h10);
        wait_done();
        $display("abort test done");
        results();
    end
endmodule
bind serial_adc_io_sequencer adc_seq_assertions #(.STEP_CYCLES(STEP_CYCLES)) u_adc_seq_assertions (
    .mclk, .rst, .cs_n, .result_oe, .eoc, .sample_track, .power_down, .dac_code,
    .channel_select, .length_select_hi, .length_select_lo, .lsb_first_select,
    .twos_complement_select);
